// *** logic/rx_status_pkg.sv ***
// Constants, register map and field layout of the adapter receive status and control block
// What this block does
// - Once armed, arriving packets are dropped until software reads receive status.
// - Any reset leaves the packet buffer assigned to the host bus.
// - At the end of a reception the receive pointer has advanced by the packet length in bytes.
// - Host loads general pointer 0..5; the PROM window returns that station address byte.
// - A runt that matches the address but is rejected, which needs short-frame detect off, stalls reception.
// - Reading receive status after a runt releases the stall.
// - Software sets short-frame detect; the device then interrupts on runt reception.
// - A write to either command register raises no spurious interrupt.
// - Auxiliary status shows receive busy in bit 0 and transmit busy in bit 7.
// - Reading receive or transmit status clears a pending interrupt request; reading the interrupt status register does not.
// - Receive status: 0x80 already read, 0x20 good, 0x10 any, 0x08..0x01 error bits.
// - Match mode in command bits: 0x00 none, 0x40 all, 0x80 broadcast, 0xc0 multicast.
// - Control buffer field: 0x08 receiver, 0x04 transmitter, 0x00 processor.
package rx_status_pkg;

   // Register indices; byte address is four times the index
   localparam logic [4:0] IDX_STATION_FIRST        = 5'h00;
   localparam logic [4:0] IDX_STATION_LAST         = 5'h05;
   localparam logic [4:0] IDX_RECEIVE_CMD          = 5'h06;
   localparam logic [4:0] IDX_TRANSMIT_CMD         = 5'h07;
   localparam logic [4:0] IDX_GENERAL_BUFFER_POINTER = 5'h08;
   localparam logic [4:0] IDX_RECEIVE_BYTE_POINTER = 5'h0a;
   localparam logic [4:0] IDX_ADDRESS_PROM_WINDOW  = 5'h0c;
   localparam logic [4:0] IDX_CONTROL              = 5'h0e;
   localparam logic [4:0] IDX_BUFFER_BYTE_WINDOW   = 5'h0f;
   localparam logic [4:0] IDX_IRQ_STATUS           = 5'h10;
   localparam logic [4:0] IDX_IRQ_CLEAR            = 5'h11;
   localparam logic [4:0] IDX_IRQ_ENABLE           = 5'h12;
   localparam int         ADDR_LSB                 = 2;
   localparam int         IDX_W                    = 5;

   // Receive command and status layout
   localparam int MATCH_LSB        = 6;
   localparam int MATCH_W          = 2;
   localparam int STATUS_ALREADY_READ = 7;
   localparam int ST_GOOD          = 5;
   localparam int ST_ANY           = 4;
   localparam int ST_SHORT         = 3;
   localparam int RX_FLAGS_W       = 6;
   localparam int ERR_W            = 4;
   localparam logic [3:0] RECEIVE_ERROR_SET = 4'hf;

   // Match modes
   localparam logic [1:0] MATCH_NONE  = 2'h0;
   localparam logic [1:0] MATCH_ALL   = 2'h1;
   localparam logic [1:0] MATCH_BROAD = 2'h2;
   localparam logic [1:0] MATCH_MULTI = 2'h3;

   // Transmit command and status layout
   localparam int TX_FLAGS_W = 4;

   // Control register layout
   localparam int CTL_RESET            = 7;
   localparam int CTL_IRQ_DMA_ENABLE   = 6;
   localparam int CTL_BUF_LSB          = 2;
   localparam int CTL_CRC              = 1;
   localparam int CTL_RX_BUSY          = 0;
   localparam int CTL_TX_BUSY          = 7;
   localparam logic [1:0] BUFFER_TO_PROCESSOR   = 2'h0;
   localparam logic [1:0] BUFFER_TO_TRANSMITTER = 2'h1;
   localparam logic [1:0] BUFFER_TO_RECEIVER    = 2'h2;

   // Packet buffer and frame sizes
   localparam int         BUF_AW       = 11;
   localparam int         PTR_W        = 12;
   localparam int         BUF_BYTES    = 2048;
   localparam logic [11:0] RUNT_BYTES  = 12'h03c;
   localparam logic [11:0] ADDR_BYTES  = 12'h006;
   localparam logic [7:0]  BCAST_BYTE  = 8'hff;

   // Interrupt event bits
   localparam int IRQ_W      = 3;
   localparam int IRQ_RX     = 0;
   localparam int IRQ_TX     = 1;
   localparam int IRQ_RUNT   = 2;

endpackage

// *** logic/packet_buffer.sv ***
// Shared packet buffer: one write port, one asynchronous read port
module packet_buffer
   import rx_status_pkg::*;
(
   // Clock
   input  wire logic              clk,
   // Write port
   input  wire logic              we,
   input  wire logic [BUF_AW-1:0] waddr,
   input  wire logic [7:0]        wdata,
   // Read port
   input  wire logic [BUF_AW-1:0] raddr,
   output logic      [7:0]        rdata
);

   logic [7:0] mem [BUF_BYTES];

   // Contents are not reset; software always fills before it reads
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Combinational read keeps the bus answer at one wait state
   assign rdata = mem[raddr];

endmodule

// *** logic/adapter_rx_ctrl.sv ***
// Receive status and control of the network adapter, registers reached over APB
//
// Decided for this implementation: the placing of the registers and the APB register port.
module adapter_rx_ctrl
   import rx_status_pkg::*;
#(
   parameter logic [47:0] PROM_BYTES = 48'h665544332211  // Arbitrary station address
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Receive byte stream from the line decoder
   input  wire logic        rx_sof,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_eof,
   input  wire logic        rx_dribble,
   input  wire logic        rx_fcs_err,
   input  wire logic        rx_overflow,
   // Transmit side
   input  wire logic        tx_active,
   input  wire logic        tx_fetch,
   input  wire logic        tx_done,
   input  wire logic [3:0]  tx_result,
   output logic             tx_enable,
   output logic [7:0]       tx_data,
   // Status and interrupt
   output logic             receive_in_progress,
   output logic             irq
);

   typedef struct packed {
      logic                  ack;
      logic [31:0]           rdata;
      logic                  slverr;
      logic [5:0][7:0]       station;
      logic [MATCH_W-1:0]    match_mode;
      logic [RX_FLAGS_W-1:0] rx_ien;
      logic [RX_FLAGS_W-1:0] rx_stat;
      logic                  already_read;
      logic                  discard;
      logic                  rx_req;
      logic [TX_FLAGS_W-1:0] tx_ien;
      logic [TX_FLAGS_W-1:0] tx_stat;
      logic                  tx_req;
      logic [PTR_W-1:0]      gp;
      logic [PTR_W-1:0]      rp;
      logic [PTR_W-1:0]      rp_start;
      logic [PTR_W-1:0]      rx_count;
      logic                  irq_dma_request_enable;
      logic [1:0]            buf_mode;
      logic                  crc_force;
      logic                  soft_rst;
      logic                  in_frame;
      logic                  station_hit;
      logic                  bcast_hit;
      logic                  mcast_hit;
      logic [IRQ_W-1:0]      irq_sticky;
      logic [IRQ_W-1:0]      irq_en;
      logic [7:0]            tx_byte;
   } state_s;

   state_s q;
   state_s next_q;

   logic                  ram_we;
   logic [BUF_AW-1:0]     ram_waddr;
   logic [7:0]            ram_wdata;
   logic [7:0]            ram_rdata;
   logic [IDX_W-1:0]      idx;
   logic                  acc;
   logic                  done;
   logic                  wr_done;
   logic                  rd_done;
   logic                  tx_busy;
   logic                  match_ok;
   logic [ERR_W-1:0]      errs;
   logic                  is_short;
   logic                  keep;
   logic [RX_FLAGS_W-1:0] new_stat;
   logic [IRQ_W-1:0]      irq_set;
   logic [IRQ_W-1:0]      irq_clr;
   logic [7:0]            rd_byte;

   packet_buffer u_buffer (
      .clk   (clk),
      .we    (ram_we),
      .waddr (ram_waddr),
      .wdata (ram_wdata),
      .raddr (q.gp[BUF_AW-1:0]),
      .rdata (ram_rdata)
   );

   // Bus decode; every access takes one wait state
   assign idx     = paddr[ADDR_LSB +: IDX_W];
   assign acc     = psel & penable;
   assign done    = acc & q.ack;
   assign wr_done = done & pwrite;
   assign rd_done = done & ~pwrite;
   assign pready  = done;
   assign prdata  = q.rdata;
   assign pslverr = q.slverr & done;

   // Busy bits seen by software
   assign tx_busy             = (q.buf_mode == BUFFER_TO_TRANSMITTER) & tx_active;
   assign receive_in_progress = q.in_frame;
   assign tx_enable           = (q.buf_mode == BUFFER_TO_TRANSMITTER) & ~q.soft_rst;
   assign tx_data             = q.tx_byte;

   // Interrupt gated by the control enable as well as the mask
   assign irq = q.irq_dma_request_enable & (|(q.irq_sticky & q.irq_en));

   // Frame verdict at end of frame
   always_comb begin
      unique case (q.match_mode)
         MATCH_NONE:  match_ok = 1'b0;
         MATCH_ALL:   match_ok = 1'b1;
         MATCH_BROAD: match_ok = q.station_hit | q.bcast_hit;
         MATCH_MULTI: match_ok = q.station_hit | q.mcast_hit;
      endcase
   end

   assign is_short = q.rx_count < RUNT_BYTES;
   assign errs     = {is_short, rx_dribble, rx_fcs_err, rx_overflow};
   // Only matching frames kept: good ones always, errored ones only if any-packet or that error is enabled
   assign keep     = match_ok & ((errs == 4'h0) | q.rx_ien[ST_ANY] | (|(errs & q.rx_ien[ERR_W-1:0])));
   assign new_stat = {(errs == 4'h0), 1'b1, errs};

   // Read multiplexer for the byte registers
   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         IDX_RECEIVE_CMD: begin
            rd_byte = {q.already_read, 1'b0, q.rx_stat};
         end
         IDX_TRANSMIT_CMD: begin
            rd_byte = {4'h0, q.tx_stat};
         end
         IDX_ADDRESS_PROM_WINDOW: begin
            if (q.gp < ADDR_BYTES) begin
               rd_byte = PROM_BYTES[8*q.gp[2:0] +: 8];
            end
         end
         IDX_CONTROL: begin
            rd_byte[CTL_TX_BUSY]                 = tx_busy;
            rd_byte[CTL_IRQ_DMA_ENABLE]          = q.irq_dma_request_enable;
            rd_byte[CTL_BUF_LSB +: 2]            = q.buf_mode;
            rd_byte[CTL_CRC]                     = q.crc_force;
            rd_byte[CTL_RX_BUSY]                 = q.in_frame;
         end
         IDX_BUFFER_BYTE_WINDOW: begin
            if (q.buf_mode == BUFFER_TO_PROCESSOR) begin
               rd_byte = ram_rdata;
            end
         end
         default: rd_byte = 8'h00;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      next_q    = q;
      ram_we    = 1'b0;
      ram_waddr = q.gp[BUF_AW-1:0];
      ram_wdata = pwdata[7:0];
      irq_set   = '0;
      irq_clr   = '0;

      // Bus access: answer prepared in the first access cycle
      next_q.ack = acc & ~q.ack;
      if (acc & ~q.ack) begin
         next_q.slverr = 1'b0;
         next_q.rdata  = 32'h00000000;
         if (idx == IDX_GENERAL_BUFFER_POINTER) begin
            next_q.rdata[PTR_W-1:0] = q.gp;
         end else if (idx == IDX_RECEIVE_BYTE_POINTER) begin
            next_q.rdata[PTR_W-1:0] = q.rp;
         end else if (idx == IDX_IRQ_STATUS) begin
            next_q.rdata[IRQ_W-1:0] = q.irq_sticky;
         end else if (idx == IDX_IRQ_ENABLE) begin
            next_q.rdata[IRQ_W-1:0] = q.irq_en;
         end else if (idx > IDX_IRQ_ENABLE) begin
            next_q.slverr = 1'b1;
         end else begin
            next_q.rdata[7:0] = rd_byte;
         end
      end

      // Register writes
      if (wr_done) begin
         if (idx <= IDX_STATION_LAST) begin
            next_q.station[idx[2:0]] = pwdata[7:0];
         end
         unique case (idx)
            IDX_RECEIVE_CMD: begin
               // Command writes raise no request themselves, so never a spurious one
               next_q.match_mode = pwdata[MATCH_LSB +: MATCH_W];
               next_q.rx_ien     = pwdata[RX_FLAGS_W-1:0];
            end
            IDX_TRANSMIT_CMD: begin
               next_q.tx_ien = pwdata[TX_FLAGS_W-1:0];
            end
            IDX_GENERAL_BUFFER_POINTER: begin
               next_q.gp = pwdata[PTR_W-1:0];
            end
            IDX_RECEIVE_BYTE_POINTER: begin
               next_q.rp = pwdata[PTR_W-1:0];
            end
            IDX_CONTROL: begin
               next_q.soft_rst               = pwdata[CTL_RESET];
               next_q.irq_dma_request_enable = pwdata[CTL_IRQ_DMA_ENABLE];
               next_q.buf_mode               = pwdata[CTL_BUF_LSB +: 2];
               next_q.crc_force              = pwdata[CTL_CRC];
            end
            IDX_BUFFER_BYTE_WINDOW: begin
               // Host buffer access only while the processor owns the buffer
               if (q.buf_mode == BUFFER_TO_PROCESSOR) begin
                  ram_we    = 1'b1;
                  next_q.gp = q.gp + 12'h001;
               end
            end
            IDX_IRQ_CLEAR: begin
               irq_clr = pwdata[IRQ_W-1:0];
            end
            IDX_IRQ_ENABLE: begin
               next_q.irq_en = pwdata[IRQ_W-1:0];
            end
            default: ;
         endcase
      end

      // Read side effects
      if (rd_done) begin
         unique case (idx)
            IDX_RECEIVE_CMD: begin
               next_q.already_read = 1'b1;
               next_q.discard      = 1'b0;
               next_q.rx_req       = 1'b0;
               irq_clr[IRQ_RX]     = 1'b1;
               irq_clr[IRQ_RUNT]   = 1'b1;
            end
            IDX_TRANSMIT_CMD: begin
               next_q.tx_req   = 1'b0;
               irq_clr[IRQ_TX] = 1'b1;
            end
            IDX_BUFFER_BYTE_WINDOW: begin
               if (q.buf_mode == BUFFER_TO_PROCESSOR) begin
                  next_q.gp = q.gp + 12'h001;
               end
            end
            default: ;
         endcase
      end

      // Frame start: only taken while armed and not discarding
      if (rx_sof & ~q.in_frame) begin
         if ((q.buf_mode == BUFFER_TO_RECEIVER) & (q.match_mode != MATCH_NONE) & ~q.discard) begin
            next_q.in_frame    = 1'b1;
            next_q.rp_start    = q.rp;
            next_q.rx_count    = 12'h000;
            next_q.station_hit = 1'b1;
            next_q.bcast_hit   = 1'b1;
            next_q.mcast_hit   = 1'b0;
         end
      end

      // Bytes go into the buffer at the receive pointer
      if (q.in_frame & rx_valid) begin
         ram_we          = 1'b1;
         ram_waddr       = q.rp[BUF_AW-1:0];
         ram_wdata       = rx_data;
         next_q.rp       = q.rp + 12'h001;
         next_q.rx_count = q.rx_count + 12'h001;
         if (q.rx_count < ADDR_BYTES) begin
            if (rx_data != q.station[q.rx_count[2:0]]) begin
               next_q.station_hit = 1'b0;
            end
            if (rx_data != BCAST_BYTE) begin
               next_q.bcast_hit = 1'b0;
            end
            if (q.rx_count == 12'h000) begin
               next_q.mcast_hit = rx_data[0];
            end
         end
      end

      // Frame end: latch fresh status, or roll back and maybe stall on a runt
      if (q.in_frame & rx_eof) begin
         next_q.in_frame = 1'b0;
         if (keep) begin
            next_q.rx_stat      = new_stat;
            next_q.already_read = 1'b0;
            next_q.discard      = 1'b1;
            if (|(new_stat & q.rx_ien)) begin
               next_q.rx_req   = 1'b1;
               irq_set[IRQ_RX] = 1'b1;
            end
            if (is_short & q.rx_ien[ST_SHORT]) begin
               irq_set[IRQ_RUNT] = 1'b1;
            end
         end else begin
            next_q.rp = q.rp_start;
            if (match_ok & is_short) begin
               // Early-board lockup kept on purpose: stall until status is read
               next_q.discard = 1'b1;
            end
         end
      end

      // Transmit fetch and completion
      if (tx_fetch & (q.buf_mode == BUFFER_TO_TRANSMITTER)) begin
         next_q.tx_byte = ram_rdata;
         next_q.gp      = q.gp + 12'h001;
      end
      if (tx_done) begin
         next_q.tx_stat = tx_result;
         if (|(tx_result & q.tx_ien)) begin
            next_q.tx_req   = 1'b1;
            irq_set[IRQ_TX] = 1'b1;
         end
      end

      // Sticky interrupt bits: a new event wins over a clear in the same cycle
      next_q.irq_sticky = (q.irq_sticky & ~irq_clr) | irq_set;

      // Software reset holds the controller idle with the buffer on the host bus
      if (q.soft_rst) begin
         next_q.buf_mode               = BUFFER_TO_PROCESSOR;
         next_q.in_frame               = 1'b0;
         next_q.discard                = 1'b1;
         next_q.already_read           = 1'b1;
         next_q.rx_stat                = '0;
         next_q.tx_stat                = '0;
         next_q.match_mode             = MATCH_NONE;
         next_q.rx_req                 = 1'b0;
         next_q.tx_req                 = 1'b0;
         next_q.irq_dma_request_enable = 1'b0;
         next_q.irq_sticky             = '0;
         if (~(wr_done & (idx == IDX_CONTROL))) begin
            next_q.soft_rst = 1'b1;
         end
      end
   end

   // State register; reset gives the buffer to the processor
   always_ff @(posedge clk) begin
      if (rst) begin
         q              <= '0;
         q.buf_mode     <= BUFFER_TO_PROCESSOR;
         q.already_read <= 1'b1;
         q.discard      <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

endmodule

// *** tb/adapter_rx_ctrl_chk.sv ***
// Port-level assertions for the adapter receive control block
module adapter_rx_ctrl_chk
   import rx_status_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Stream and status
   input wire logic        rx_sof,
   input wire logic        rx_eof,
   input wire logic        tx_done,
   input wire logic        tx_enable,
   input wire logic        receive_in_progress,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Register index of the current transfer
   wire [4:0] idx = paddr[6:2];

   // APB answer timing: one wait state, never zero
   a_one_wait: assert property ($rose(penable) && psel |-> !pready)
      else $error("pready in first access cycle");
   a_answer_next: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing in second access cycle");
   a_unmapped_err: assert property (pready |-> pslverr == (idx > 5'h12))
      else $error("pslverr does not match address map");
   a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_quiet_reset: assert property ($fell(rst) |-> !irq && !receive_in_progress && !tx_enable)
      else $error("outputs active after reset");
   // Frame acceptance only follows a frame start
   a_no_start: assert property (!receive_in_progress && !rx_sof |=> !receive_in_progress)
      else $error("reception began without frame start");
   a_start_cause: assert property ($rose(receive_in_progress) |-> $past(rx_sof))
      else $error("busy rose without frame start");
   a_busy_ends: assert property (rx_eof && receive_in_progress |=> !receive_in_progress)
      else $error("busy held after frame end");
   // Command writes must not raise a request here, as no spurious ones are built
   a_cmd_no_spur: assert property (pready && pwrite && (idx == IDX_RECEIVE_CMD || idx == IDX_TRANSMIT_CMD)
      && !irq && !rx_eof && !tx_done && !$past(tx_done) |=> !irq)
      else $error("interrupt raised by command write");

   // Main scenarios reached
   c_frame: cover property ($rose(receive_in_progress));
   c_err: cover property (pready && pslverr);
   c_irq: cover property ($rose(irq));
endmodule
bind adapter_rx_ctrl adapter_rx_ctrl_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_sof(rx_sof),
   .rx_eof(rx_eof), .tx_done(tx_done), .tx_enable(tx_enable),
   .receive_in_progress(receive_in_progress), .irq(irq));

// *** tb/rx_src.sv ***
// Line decoder stand-in that sends receive frames byte by byte
module rx_src (
   // Clock
   input wire logic  clk,
   // Receive stream
   output logic       rx_sof,
   output logic       rx_valid,
   output logic [7:0] rx_data,
   output logic       rx_eof,
   output logic       rx_dribble,
   output logic       rx_fcs_err,
   output logic       rx_overflow
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet line at time zero
   initial begin
      {rx_sof, rx_valid, rx_eof, rx_dribble, rx_fcs_err, rx_overflow} = 6'h00;
      rx_data = 8'h00;
   end

   // Frame of n bytes; end marker in a cycle with no byte, carrying {dribble, fcs, overflow}
   task automatic send(input int n, input logic [2:0] e = 3'h0);
      @(posedge clk);
      rx_sof <= 1'b1;
      @(posedge clk);
      rx_sof <= 1'b0;
      for (int i = 0; i < n; i++) begin
         rx_valid <= 1'b1;
         rx_data <= i[7:0];
         @(posedge clk);
      end
      rx_valid <= 1'b0;
      rx_data <= ~rx_data; // Released data must not look valid
      rx_eof <= 1'b1;
      {rx_dribble, rx_fcs_err, rx_overflow} <= e;
      @(posedge clk);
      rx_eof <= 1'b0;
      {rx_dribble, rx_fcs_err, rx_overflow} <= 3'h0;
      repeat (3) @(posedge clk);
   endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the adapter receive status and control block
module tb
   import rx_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [47:0] PROM = 48'h0a1b2c3d4e5f; // Arbitrary station address
   typedef struct {logic [4:0] ix; logic w; logic [31:0] d; logic [31:0] e;} row_s;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, tx_active, irq, rip, err;
   logic        tx_fetch, tx_done, tx_en;
   logic [3:0]  tx_result;
   logic [7:0]  paddr, rx_data, tx_q;
   logic [31:0] pwdata, prdata, rd;
   logic        rx_sof, rx_valid, rx_eof, rx_dribble, rx_fcs_err, rx_overflow;
   int          miscompares, num_checks;
   row_s        rows[14];

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Device and line model; the bench plays the transmitter
   adapter_rx_ctrl #(.PROM_BYTES(PROM)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof), .rx_dribble(rx_dribble),
      .rx_fcs_err(rx_fcs_err), .rx_overflow(rx_overflow), .tx_active(tx_active), .tx_fetch(tx_fetch),
      .tx_done(tx_done), .tx_result(tx_result), .tx_enable(tx_en), .tx_data(tx_q), .receive_in_progress(rip),
      .irq(irq));
   rx_src src (.clk(clk), .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
      .rx_dribble(rx_dribble), .rx_fcs_err(rx_fcs_err), .rx_overflow(rx_overflow));

   task automatic final_report();
      if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high at a rising edge
   task automatic apb(input logic [4:0] ix, input logic w, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {1'b0, ix, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Interrupt level is looked at once the edge's updates have landed
   task automatic irqc(input logic e);
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   initial begin
      {rst, psel, penable, pwrite, tx_active} = 5'h10;
      {tx_fetch, tx_done, tx_result} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      miscompares = 0;
      num_checks = 0;
      for (int i = 0; i < 7; i++) begin
         rows[2*i] = '{IDX_GENERAL_BUFFER_POINTER, 1'b1, i, 32'h0};
         rows[2*i+1] = '{IDX_ADDRESS_PROM_WINDOW, 1'b0, 32'h0, (i < 6) ? 32'(PROM[8*i+:8]) : 32'h0};
      end
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // Station address bytes through the pointer and window
      foreach (rows[k]) begin
         apb(rows[k].ix, rows[k].w, rows[k].d);
         if (!rows[k].w) chk(rd, rows[k].e);
      end
      // Reset state and an unmapped place
      apb(IDX_CONTROL, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(5'h13, 1'b0, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      // Armed receiver drops frames until status is read
      apb(IDX_RECEIVE_CMD, 1'b1, 32'h60);
      apb(IDX_IRQ_ENABLE, 1'b1, 32'h5);
      apb(IDX_CONTROL, 1'b1, 32'h48);
      src.send(64);
      apb(IDX_RECEIVE_BYTE_POINTER, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(IDX_RECEIVE_CMD, 1'b0, 32'h0);
      chk(rd, 32'h80);
      src.send(64);
      apb(IDX_RECEIVE_BYTE_POINTER, 1'b0, 32'h0);
      chk(rd, 32'd64);
      irqc(1'b1);
      apb(IDX_BUFFER_BYTE_WINDOW, 1'b0, 32'h0);
      chk(rd, 32'h0);
      // Interrupt masked, unmasked, cleared
      apb(IDX_IRQ_ENABLE, 1'b1, 32'h0);
      irqc(1'b0);
      apb(IDX_IRQ_ENABLE, 1'b1, 32'h5);
      irqc(1'b1);
      apb(IDX_IRQ_CLEAR, 1'b1, 32'h7);
      irqc(1'b0);
      apb(IDX_RECEIVE_CMD, 1'b0, 32'h0);
      chk(rd & 32'haf, 32'h20);
      // Hand back, stop, rearm; then a runt with short detect off stalls
      apb(IDX_CONTROL, 1'b1, 32'h40);
      apb(IDX_RECEIVE_CMD, 1'b1, 32'h0);
      apb(IDX_RECEIVE_BYTE_POINTER, 1'b1, 32'h0);
      apb(IDX_RECEIVE_CMD, 1'b1, 32'h60);
      apb(IDX_CONTROL, 1'b1, 32'h48);
      src.send(20);
      src.send(64);
      apb(IDX_RECEIVE_BYTE_POINTER, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(IDX_RECEIVE_CMD, 1'b0, 32'h0);
      src.send(64);
      apb(IDX_RECEIVE_BYTE_POINTER, 1'b0, 32'h0);
      chk(rd, 32'd64);
      // Runt with short detect on interrupts; status read clears it
      apb(IDX_RECEIVE_CMD, 1'b0, 32'h0);
      apb(IDX_RECEIVE_CMD, 1'b1, 32'h68);
      src.send(20);
      irqc(1'b1);
      apb(IDX_IRQ_STATUS, 1'b0, 32'h0);
      chk(rd & 32'h4, 32'h4);
      apb(IDX_RECEIVE_CMD, 1'b0, 32'h0);
      chk(rd & 32'h88, 32'h08);
      irqc(1'b0);
      // Errored frame kept by its enable; receive busy shows while it lands
      apb(IDX_RECEIVE_CMD, 1'b1, 32'h6a);
      fork
         src.send(64, 3'h7);
         begin
            apb(IDX_CONTROL, 1'b0, 32'h0);
            chk(rd, 32'h49);
            @(negedge clk);
            chk({31'h0, rip}, 32'h1);
         end
      join
      apb(IDX_RECEIVE_CMD, 1'b0, 32'h0);
      chk(rd, 32'h17);
      // Even-length packet ending at the buffer top, fetched once, then completed
      apb(IDX_CONTROL, 1'b1, 32'h40);
      apb(IDX_GENERAL_BUFFER_POINTER, 1'b1, 32'(BUF_BYTES - 2));
      apb(IDX_BUFFER_BYTE_WINDOW, 1'b1, 32'ha5);
      apb(IDX_BUFFER_BYTE_WINDOW, 1'b1, 32'h5a);
      apb(IDX_GENERAL_BUFFER_POINTER, 1'b1, 32'(BUF_BYTES - 2));
      apb(IDX_TRANSMIT_CMD, 1'b1, 32'h8);
      apb(IDX_IRQ_ENABLE, 1'b1, 32'h2);
      apb(IDX_CONTROL, 1'b1, 32'h44);
      // Busy bits seen before disturbing the controller
      tx_active <= 1'b1;
      apb(IDX_CONTROL, 1'b0, 32'h0);
      chk(rd, 32'hc4);
      tx_fetch <= 1'b1;
      @(posedge clk);
      {tx_fetch, tx_done, tx_result} <= 6'h18;
      @(posedge clk);
      tx_done <= 1'b0;
      irqc(1'b1);
      chk({tx_en, tx_q}, 32'h1a5);
      apb(IDX_TRANSMIT_CMD, 1'b0, 32'h0);
      chk(rd, 32'h8);
      irqc(1'b0);
      // Software reset in mid-run hands the buffer back with status_already_read receive status
      apb(IDX_CONTROL, 1'b1, 32'h80);
      apb(IDX_CONTROL, 1'b1, 32'h0);
      apb(IDX_CONTROL, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(IDX_RECEIVE_CMD, 1'b0, 32'h0);
      chk(rd & 32'h9f, 32'h80);
      final_report();
   end
endmodule
